// ---- verilog/eies_top.sv ----
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/10ps
// How it works
// - Enable pair per pin: none, rising, falling or both edges detected.
// - Group one bit 0 drives pin 9, bit 1 drives pin 10.
// - Group three bit 1 drives pin 7, bit 9 drives pin 8.
// - Group three registers are accessed as whole 16-bit values.
// - Group three falling register also reachable as upper and lower bytes.
// - Reset clears every edge-select register; detection starts disabled.
// - Group six low bits 0 to 2 drive pins 11 to 13; rest zero.
// - Group eight bit 0 holds rise and fall enables of pin 14.
// - Group nine high bits 13 to 15 drive pins 4 to 6; rest zero.
// - Groups one, six, eight and nine accept byte-wide accesses.
// - A request rises only on an edge matching the enabled selection.
module eies_top
  import eies_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        ext_irq_pin_4,
  input  wire logic        ext_irq_pin_5,
  input  wire logic        ext_irq_pin_6,
  input  wire logic        ext_irq_pin_7,
  input  wire logic        ext_irq_pin_8,
  input  wire logic        ext_irq_pin_9,
  input  wire logic        ext_irq_pin_10,
  input  wire logic        ext_irq_pin_11,
  input  wire logic        ext_irq_pin_12,
  input  wire logic        ext_irq_pin_13,
  input  wire logic        ext_irq_pin_14,
  output logic             irq_req_4,
  output logic             irq_req_5,
  output logic             irq_req_6,
  output logic             irq_req_7,
  output logic             irq_req_8,
  output logic             irq_req_9,
  output logic             irq_req_10,
  output logic             irq_req_11,
  output logic             irq_req_12,
  output logic             irq_req_13,
  output logic             irq_req_14,
  output logic             irq
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic                    rst_meta;
  logic                    rst_n;
  logic                    wr_pend;
  logic [EIES_DEC_W-1:0]   wr_idx;
  logic                    ap_valid;
  logic [EIES_DEC_W-1:0]   ap_idx;
  logic [31:0]             next_rdata;
  logic [7:0]              rise_sel_grp1;
  logic [7:0]              fall_sel_grp1;
  logic [15:0]             rise_sel_grp3;
  logic [15:0]             fall_sel_grp3;
  logic [7:0]              rise_sel_grp6_low;
  logic [7:0]              fall_sel_grp6_low;
  logic [7:0]              rise_sel_grp8;
  logic [7:0]              fall_sel_grp8;
  logic [7:0]              rise_sel_grp9_high;
  logic [7:0]              fall_sel_grp9_high;
  logic [EIES_NPINS-1:0]   irq_status;
  logic [EIES_NPINS-1:0]   irq_mask;
  logic [EIES_NPINS-1:0]   next_status;
  logic [EIES_NPINS-1:0]   pin_vec;
  logic [EIES_NPINS-1:0]   rise_en;
  logic [EIES_NPINS-1:0]   fall_en;
  logic [EIES_NPINS-1:0]   req;

  // Decode helper: does the given word index (pending write or read address phase) hit this register index
  function automatic logic hit(input logic [EIES_DEC_W-1:0] idx,
                               input logic [31:0]           reg_idx);
    hit = (idx == reg_idx[EIES_DEC_W-1:0]);
  endfunction : hit

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  // Assert at once, release through two flops to avoid a ragged release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------------
  assign ap_valid = hsel & htrans[1] & hready;
  assign ap_idx   = haddr[EIES_DEC_W+1:2];

  // Write address captured in the address phase, data taken next cycle.
  // Only whole-word transfers are expected; hsize is not checked.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_idx  <= '0;
    end else begin
      wr_pend <= ap_valid & hwrite;
      if (ap_valid & hwrite) begin
        wr_idx <= ap_idx;
      end
    end
  end

  // Zero wait states and always OKAY
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Read mux; unmapped indices and reserved bits read as zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit(ap_idx, EIES_IDX_RISE1)) begin
      next_rdata[7:0] = rise_sel_grp1;
    end else if (hit(ap_idx, EIES_IDX_FALL1)) begin
      next_rdata[7:0] = fall_sel_grp1;
    end else if (hit(ap_idx, EIES_IDX_RISE3)) begin
      next_rdata[15:0] = rise_sel_grp3;
    end else if (hit(ap_idx, EIES_IDX_FALL3)) begin
      next_rdata[15:0] = fall_sel_grp3;
    end else if (hit(ap_idx, EIES_IDX_FALL3U)) begin
      next_rdata[7:0] = fall_sel_grp3[15:8];
    end else if (hit(ap_idx, EIES_IDX_FALL3L)) begin
      next_rdata[7:0] = fall_sel_grp3[7:0];
    end else if (hit(ap_idx, EIES_IDX_RISE6L)) begin
      next_rdata[7:0] = rise_sel_grp6_low;
    end else if (hit(ap_idx, EIES_IDX_FALL6L)) begin
      next_rdata[7:0] = fall_sel_grp6_low;
    end else if (hit(ap_idx, EIES_IDX_RISE8)) begin
      next_rdata[7:0] = rise_sel_grp8;
    end else if (hit(ap_idx, EIES_IDX_FALL8)) begin
      next_rdata[7:0] = fall_sel_grp8;
    end else if (hit(ap_idx, EIES_IDX_RISE9H)) begin
      next_rdata[7:0] = rise_sel_grp9_high;
    end else if (hit(ap_idx, EIES_IDX_FALL9H)) begin
      next_rdata[7:0] = fall_sel_grp9_high;
    end else if (hit(ap_idx, EIES_IDX_STAT)) begin
      next_rdata[EIES_NPINS-1:0] = irq_status;
    end else if (hit(ap_idx, EIES_IDX_MASK)) begin
      next_rdata[EIES_NPINS-1:0] = irq_mask;
    end
  end

  // Read data registered at the address phase so it stands in the data
  // phase; a read right behind a write sees the value before that write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_valid & ~hwrite) begin
      hrdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Edge-select registers
  // ----------------------------------------------------------------------
  // Group one: pins 9 and 10
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_sel_grp1 <= EIES_RST8;
      fall_sel_grp1 <= EIES_RST8;
    end else if (wr_pend) begin
      if (hit(wr_idx, EIES_IDX_RISE1)) begin
        rise_sel_grp1 <= hwdata[7:0] & EIES_BITS_GRP1;
      end
      if (hit(wr_idx, EIES_IDX_FALL1)) begin
        fall_sel_grp1 <= hwdata[7:0] & EIES_BITS_GRP1;
      end
    end
  end

  // Group three rising: whole 16-bit value only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_sel_grp3 <= EIES_RST16;
    end else if (wr_pend && hit(wr_idx, EIES_IDX_RISE3)) begin
      rise_sel_grp3 <= hwdata[15:0] & EIES_BITS_GRP3;
    end
  end

  // Group three falling: one store, three windows onto it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fall_sel_grp3 <= EIES_RST16;
    end else if (wr_pend) begin
      if (hit(wr_idx, EIES_IDX_FALL3)) begin
        fall_sel_grp3 <= hwdata[15:0] & EIES_BITS_GRP3;
      end else if (hit(wr_idx, EIES_IDX_FALL3U)) begin
        fall_sel_grp3[15:8] <= hwdata[7:0] & EIES_BITS_GRP3[15:8];
      end else if (hit(wr_idx, EIES_IDX_FALL3L)) begin
        fall_sel_grp3[7:0] <= hwdata[7:0] & EIES_BITS_GRP3[7:0];
      end
    end
  end

  // Group six low: pins 11 to 13
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_sel_grp6_low <= EIES_RST8;
      fall_sel_grp6_low <= EIES_RST8;
    end else if (wr_pend) begin
      if (hit(wr_idx, EIES_IDX_RISE6L)) begin
        rise_sel_grp6_low <= hwdata[7:0] & EIES_BITS_GRP6;
      end
      if (hit(wr_idx, EIES_IDX_FALL6L)) begin
        fall_sel_grp6_low <= hwdata[7:0] & EIES_BITS_GRP6;
      end
    end
  end

  // Group eight: pin 14, shared with the serial receive input
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_sel_grp8 <= EIES_RST8;
      fall_sel_grp8 <= EIES_RST8;
    end else if (wr_pend) begin
      if (hit(wr_idx, EIES_IDX_RISE8)) begin
        rise_sel_grp8 <= hwdata[7:0] & EIES_BITS_GRP8;
      end
      if (hit(wr_idx, EIES_IDX_FALL8)) begin
        fall_sel_grp8 <= hwdata[7:0] & EIES_BITS_GRP8;
      end
    end
  end

  // Group nine high: pins 4 to 6, bits 13 to 15 held in bits 5 to 7
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_sel_grp9_high <= EIES_RST8;
      fall_sel_grp9_high <= EIES_RST8;
    end else if (wr_pend) begin
      if (hit(wr_idx, EIES_IDX_RISE9H)) begin
        rise_sel_grp9_high <= hwdata[7:0] & EIES_BITS_GRP9;
      end
      if (hit(wr_idx, EIES_IDX_FALL9H)) begin
        fall_sel_grp9_high <= hwdata[7:0] & EIES_BITS_GRP9;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pin to enable mapping (vector bit k is pin 4+k)
  // ----------------------------------------------------------------------
  assign pin_vec = {ext_irq_pin_14, ext_irq_pin_13, ext_irq_pin_12,
                    ext_irq_pin_11, ext_irq_pin_10, ext_irq_pin_9,
                    ext_irq_pin_8,  ext_irq_pin_7,  ext_irq_pin_6,
                    ext_irq_pin_5,  ext_irq_pin_4};

  // Rising enables gathered from the groups
  assign rise_en = {rise_sel_grp8[0],
                    rise_sel_grp6_low[2:0],
                    rise_sel_grp1[1:0],
                    rise_sel_grp3[EIES_POS_PIN8],
                    rise_sel_grp3[EIES_POS_PIN7],
                    rise_sel_grp9_high[EIES_POS_PIN4+:3]};

  // Falling enables gathered the same way
  assign fall_en = {fall_sel_grp8[0],
                    fall_sel_grp6_low[2:0],
                    fall_sel_grp1[1:0],
                    fall_sel_grp3[EIES_POS_PIN8],
                    fall_sel_grp3[EIES_POS_PIN7],
                    fall_sel_grp9_high[EIES_POS_PIN4+:3]};

  // ----------------------------------------------------------------------
  // Edge detectors
  // ----------------------------------------------------------------------
  // Pin 14 is watched whatever the serial receiver does; software keeps
  // its enables clear while the receiver owns the pin
  eies_edge_det #(
    .N         (EIES_NPINS)
  ) u_det (
    .clk       (clk),
    .rst_n     (rst_n),
    .pin_async (pin_vec),
    .rise_en   (rise_en),
    .fall_en   (fall_en),
    .req       (req)
  );

  // Request pulses leave straight from the detector flops
  assign irq_req_4  = req[0];
  assign irq_req_5  = req[1];
  assign irq_req_6  = req[2];
  assign irq_req_7  = req[3];
  assign irq_req_8  = req[4];
  assign irq_req_9  = req[5];
  assign irq_req_10 = req[6];
  assign irq_req_11 = req[7];
  assign irq_req_12 = req[8];
  assign irq_req_13 = req[9];
  assign irq_req_14 = req[10];

  // ----------------------------------------------------------------------
  // Sticky status, mask and interrupt line
  // ----------------------------------------------------------------------
  // Write one to clear; a request in the clearing cycle still sets
  always_comb begin
    next_status = irq_status;
    if (wr_pend && hit(wr_idx, EIES_IDX_STAT)) begin
      next_status = irq_status & ~hwdata[EIES_NPINS-1:0];
    end
    next_status = next_status | req;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= EIES_RST_IRQ;
    end else begin
      irq_status <= next_status;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= EIES_RST_IRQ;
    end else if (wr_pend && hit(wr_idx, EIES_IDX_MASK)) begin
      irq_mask <= hwdata[EIES_NPINS-1:0] & EIES_BITS_IRQ;
    end
  end

  // Registered line; lags the status bit by one clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

endmodule : eies_top

// ---- verilog/eies_pkg.sv ----
package eies_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int EIES_NPINS = 11;  // Pins 4 to 14
  localparam int EIES_DEC_W = 10;  // Word index bits decoded from haddr

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [31:0] EIES_IDX_RISE1  = 32'hfffffc22;
  localparam logic [31:0] EIES_IDX_FALL1  = 32'hfffffc02;
  localparam logic [31:0] EIES_IDX_RISE3  = 32'hfffffc40;
  localparam logic [31:0] EIES_IDX_FALL3  = 32'hfffffc41;
  localparam logic [31:0] EIES_IDX_FALL3U = 32'hfffffc42;
  localparam logic [31:0] EIES_IDX_FALL3L = 32'hfffffc43;
  localparam logic [31:0] EIES_IDX_RISE6L = 32'hfffffc0c;
  localparam logic [31:0] EIES_IDX_FALL6L = 32'hfffffc2c;
  localparam logic [31:0] EIES_IDX_RISE8  = 32'hfffffc44;
  localparam logic [31:0] EIES_IDX_FALL8  = 32'hfffffc45;
  localparam logic [31:0] EIES_IDX_RISE9H = 32'hfffffc33;
  localparam logic [31:0] EIES_IDX_FALL9H = 32'hfffffc13;
  localparam logic [31:0] EIES_IDX_STAT   = 32'hfffffc48;
  localparam logic [31:0] EIES_IDX_MASK   = 32'hfffffc49;

  // ----------------------------------------------------------------------
  // Implemented bits of each register
  // ----------------------------------------------------------------------
  localparam logic [7:0]  EIES_BITS_GRP1 = 8'h03;
  localparam logic [15:0] EIES_BITS_GRP3 = 16'h0202;
  localparam logic [7:0]  EIES_BITS_GRP6 = 8'h07;
  localparam logic [7:0]  EIES_BITS_GRP8 = 8'h01;
  localparam logic [7:0]  EIES_BITS_GRP9 = 8'he0;
  localparam logic [10:0] EIES_BITS_IRQ  = 11'h7ff;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int EIES_POS_PIN7 = 1;  // Group 3 bit for pin 7
  localparam int EIES_POS_PIN8 = 9;  // Group 3 bit for pin 8
  localparam int EIES_POS_PIN4 = 5;  // Bit 13 sits at bit 5 of the byte

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  EIES_RST8    = 8'h00;
  localparam logic [15:0] EIES_RST16   = 16'h0000;
  localparam logic [10:0] EIES_RST_IRQ = 11'h000;

endpackage : eies_pkg

// ---- verilog/eies_edge_det.sv ----
`timescale 1ns/10ps
// Per-pin synchroniser and edge detector with one-clock request pulses
module eies_edge_det #(
  parameter int N = 11
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] pin_async,
  input  wire logic [N-1:0] rise_en,
  input  wire logic [N-1:0] fall_en,
  output logic      [N-1:0] req
);

  logic [N-1:0] sync1;
  logic [N-1:0] sync2;
  logic [N-1:0] prev;

  // ----------------------------------------------------------------------
  // Detector per pin
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_pin
      // Two flops before any logic; prev tracks even when disabled so that
      // enabling a pin never fires on stale history
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sync1[i] <= 1'b0;
          sync2[i] <= 1'b0;
          prev[i]  <= 1'b0;
          req[i]   <= 1'b0;
        end else begin
          sync1[i] <= pin_async[i];
          sync2[i] <= sync1[i];
          prev[i]  <= sync2[i];
          // Decode of the enable pair: none, rise, fall or both
          req[i]   <= (rise_en[i] & sync2[i] & ~prev[i]) |
                      (fall_en[i] & ~sync2[i] & prev[i]);
        end
      end
    end
  endgenerate

endmodule : eies_edge_det

// ---- sim/eies_pin_drv.sv ----
`timescale 1ns/10ps
// --------------------------------------------------------------------
// Far-side pin driver for the external request inputs
// --------------------------------------------------------------------
module eies_pin_drv (
  input  wire logic        clk,
  input  wire logic [10:0] want,
  input  wire logic        slow,
  input  wire logic        rx_mode,
  output logic      [10:0] pins
);
  logic rx_bit = 1'b1;

  // Pins start low so the synchronisers never see an unknown
  initial pins = 11'h000;

  // Receiver traffic toggles the shared pin every cycle while it owns it
  always @(posedge clk) begin
    rx_bit <= ~rx_bit;
  end

  // Slow mode lands late in the cycle, close to the next sampling edge
  always @(posedge clk) begin
    pins[9:0] <= #(slow ? 7 : 1) want[9:0];
    pins[10]  <= #(slow ? 7 : 1) (rx_mode ? rx_bit : want[10]);
  end
endmodule : eies_pin_drv

// ---- sim/eies_props.sv ----
`timescale 1ns/10ps
// --------------------------------------------------------------------
// Port checker for the edge select block
// --------------------------------------------------------------------
module eies_props (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        irq,
  input wire logic        ext_irq_pin_9,
  input wire logic        ext_irq_pin_14,
  input wire logic        irq_req_9,
  input wire logic        irq_req_14
);
  logic rd_take;
  logic wr_take;

  // Transfers accepted on the bus
  assign rd_take = hsel && htrans[1] && !hwrite && hreadyout;
  assign wr_take = hsel && htrans[1] && hwrite && hreadyout;

  // Implemented bits per word index; anything else must read zero
  function automatic logic [31:0] msk(input logic [9:0] a);
    case (a)
      10'h022, 10'h002: msk = 32'h00000003;
      10'h040, 10'h041: msk = 32'h00000202;
      10'h042, 10'h043: msk = 32'h00000002;
      10'h00c, 10'h02c: msk = 32'h00000007;
      10'h044, 10'h045: msk = 32'h00000001;
      10'h033, 10'h013: msk = 32'h000000e0;
      10'h048, 10'h049: msk = 32'h000007ff;
      default:          msk = 32'h00000000;
    endcase
  endfunction : msk

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_read;
    rd_take;
  endsequence
  sequence s_start;
    $rose(arst_n);
  endsequence

  a_ready_high: assert property (hreadyout)
    else $error("hreadyout dropped");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not OKAY");
  a_rsvd_zero: assert property (s_read |=>
    (hrdata & ~msk($past(haddr[11:2]))) == 32'h00000000)
    else $error("reserved read bits not zero");
  a_rdata_stands: assert property ($changed(hrdata) |-> $past(rd_take))
    else $error("hrdata changed without a read");
  a_req9_edge: assert property (irq_req_9 |->
    $past(ext_irq_pin_9, 3) != $past(ext_irq_pin_9, 4))
    else $error("pin 9 request without an edge");
  a_req14_edge: assert property (irq_req_14 |->
    $past(ext_irq_pin_14, 3) != $past(ext_irq_pin_14, 4))
    else $error("pin 14 request without an edge");
  a_irq_fall_cause: assert property ($fell(irq) |->
    $past(wr_take, 2) || $past(wr_take, 3) || $past(wr_take, 4))
    else $error("irq dropped without a write");
  a_quiet_start: assert property (s_start |->
    (!irq && !irq_req_9 && !irq_req_14) [*3])
    else $error("request right after reset");
endmodule : eies_props

bind eies_top eies_props u_props (
  .clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .irq(irq),
  .ext_irq_pin_9(ext_irq_pin_9), .ext_irq_pin_14(ext_irq_pin_14),
  .irq_req_9(irq_req_9), .irq_req_14(irq_req_14)
);

// ---- sim/ext_irq_edge_select_bench.sv ----
`timescale 1ns/10ps
module ext_irq_edge_select_bench;
  import eies_pkg::*;
  // ------------------------------------------------------------------
  // Signals and model state (bit k stands for pin 4+k)
  // ------------------------------------------------------------------
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = 32'h00000000;
  logic [31:0] hwdata = 32'h00000000;
  logic        slow = 1'b0;
  logic        rx_mode = 1'b0;
  logic [10:0] want = 11'h000;
  logic [10:0] rm = 11'h000;
  logic [10:0] fm = 11'h000;
  logic [10:0] st = 11'h000;
  logic [10:0] seen;
  logic [10:0] pins;
  logic [10:0] req;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  int          bad_count = 0;
  int          tests_run = 0;
  localparam logic [31:0] IDX [14] = '{EIES_IDX_RISE1, EIES_IDX_FALL1,
    EIES_IDX_RISE3, EIES_IDX_FALL3, EIES_IDX_FALL3U, EIES_IDX_FALL3L,
    EIES_IDX_RISE6L, EIES_IDX_FALL6L, EIES_IDX_RISE8, EIES_IDX_FALL8,
    EIES_IDX_RISE9H, EIES_IDX_FALL9H, EIES_IDX_STAT, EIES_IDX_MASK};
  localparam logic [31:0] MSK [14] = '{32'h3, 32'h3, 32'h202, 32'h202,
    32'h2, 32'h2, 32'h7, 32'h7, 32'h1, 32'h1, 32'he0, 32'he0, 32'h0,
    32'h7ff};

  always #5 clk = ~clk;

  eies_pin_drv u_pins (.clk(clk), .want(want), .slow(slow),
    .rx_mode(rx_mode), .pins(pins));
  eies_top dut (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .ext_irq_pin_4(pins[0]), .ext_irq_pin_5(pins[1]),
    .ext_irq_pin_6(pins[2]), .ext_irq_pin_7(pins[3]),
    .ext_irq_pin_8(pins[4]), .ext_irq_pin_9(pins[5]),
    .ext_irq_pin_10(pins[6]), .ext_irq_pin_11(pins[7]),
    .ext_irq_pin_12(pins[8]), .ext_irq_pin_13(pins[9]),
    .ext_irq_pin_14(pins[10]), .irq_req_4(req[0]), .irq_req_5(req[1]),
    .irq_req_6(req[2]), .irq_req_7(req[3]), .irq_req_8(req[4]),
    .irq_req_9(req[5]), .irq_req_10(req[6]), .irq_req_11(req[7]),
    .irq_req_12(req[8]), .irq_req_13(req[9]), .irq_req_14(req[10]),
    .irq(irq));

  // ------------------------------------------------------------------
  // Reporting and bus tasks
  // ------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("Mismatches %0d in %0d checks", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  task automatic note(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : note

  // Bounded wait for hready; a stuck bus ends the run
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      bad_count++;
      tally_and_finish();
    end
  endtask : wait_rdy

  // One single transfer, entered just after a rising edge
  task automatic bus(input logic [31:0] idx, input logic wr,
                     input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {idx[29:0], 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : bus

  // Spread one enable vector over its five registers
  task automatic put_sel(input logic [10:0] v, input logic [31:0] i9,
      input logic [31:0] i3, input logic [31:0] i1, input logic [31:0] i6,
      input logic [31:0] i8);
    bus(i9, 1'b1, {24'h000000, v[2:0], 5'h00});
    bus(i3, 1'b1, {22'h000000, v[4], 7'h00, v[3], 1'b0});
    bus(i1, 1'b1, {30'h00000000, v[6:5]});
    bus(i6, 1'b1, {29'h00000000, v[9:7]});
    bus(i8, 1'b1, {31'h00000000, v[10]});
  endtask : put_sel

  task automatic set_sel(input logic [10:0] r, input logic [10:0] f);
    rm = r;
    fm = f;
    put_sel(r, EIES_IDX_RISE9H, EIES_IDX_RISE3, EIES_IDX_RISE1,
      EIES_IDX_RISE6L, EIES_IDX_RISE8);
    put_sel(f, EIES_IDX_FALL9H, EIES_IDX_FALL3, EIES_IDX_FALL1,
      EIES_IDX_FALL6L, EIES_IDX_FALL8);
  endtask : set_sel

  // Flip one pin; exactly the selected request may pulse
  task automatic pulse_chk(input int k);
    logic sel;
    seen = 11'h000;
    sel = want[k] ? fm[k] : rm[k];
    want[k] <= ~want[k];
    repeat (7) begin
      @(posedge clk);
      seen = seen | req;
    end
    note({21'h000000, seen}, {21'h000000, 11'(sel) << k});
    st[k] = st[k] | sel;
  endtask : pulse_chk

  // ------------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(71078));
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // Reset reads first: the byte windows alias the 16-bit falling store
    for (int i = 0; i < 14; i++) begin
      bus(IDX[i], 1'b0, 32'h0);
      note(rd, 32'h0);
    end
    for (int i = 0; i < 14; i++) begin
      bus(IDX[i], 1'b1, 32'hffffffff);
      bus(IDX[i], 1'b0, 32'h0);
      note(rd, MSK[i]);
    end
    bus(EIES_IDX_FALL3, 1'b1, 32'h00000200);
    bus(EIES_IDX_FALL3U, 1'b0, 32'h0);
    note(rd, 32'h00000002);
    bus(EIES_IDX_FALL3L, 1'b0, 32'h0);
    note(rd, 32'h00000000);
    bus(EIES_IDX_FALL3L, 1'b1, 32'h00000002);
    bus(EIES_IDX_FALL3, 1'b0, 32'h0);
    note(rd, 32'h00000202);
    bus(32'hfffffc50, 1'b1, 32'hffffffff);
    bus(32'hfffffc50, 1'b0, 32'h0);
    note(rd, 32'h00000000);
    bus(EIES_IDX_MASK, 1'b1, 32'h0);
    for (int m = 0; m < 4; m++) begin
      set_sel({11{m[0]}}, {11{m[1]}});
      for (int k = 0; k < 11; k++) begin
        pulse_chk(k);
        pulse_chk(k);
      end
    end
    for (int r = 0; r < 24; r++) begin
      set_sel(11'($urandom), 11'($urandom));
      slow <= 1'($urandom);
      pulse_chk($urandom_range(10, 0));
    end
    bus(EIES_IDX_STAT, 1'b0, 32'h0);
    note(rd, {21'h000000, st});
    note({31'h0, irq}, 32'h0);
    bus(EIES_IDX_STAT, 1'b1, 32'h1);
    st[0] = 1'b0;
    bus(EIES_IDX_MASK, 1'b1, 32'h1);
    set_sel(11'h001, 11'h000);
    want[0] <= 1'b0;
    repeat (8) @(posedge clk);
    pulse_chk(0);
    repeat (2) @(posedge clk);
    note({31'h0, irq}, 32'h1);
    bus(EIES_IDX_STAT, 1'b1, 32'h7ff);
    repeat (3) @(posedge clk);
    note({31'h0, irq}, 32'h0);
    set_sel(11'h000, 11'h000);
    rx_mode <= 1'b1;
    seen = 11'h000;
    repeat (40) begin
      @(posedge clk);
      seen = seen | req;
    end
    note({21'h000000, seen}, 32'h0);
    rx_mode <= 1'b0;
    tally_and_finish();
  end
endmodule : ext_irq_edge_select_bench
